// file: common/ump_pkg.sv
// Purpose: constants and carrier types for the multiprocessor serial port
// Assumes: one 40 MHz system clock, synchronous active-low reset
// Notes: register addresses are the special-function-register addresses
package ump_pkg;

  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // control register bit positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;

  // fixed-rate mode divides the system clock by 64 (or 32 doubled)
  localparam int FIXED_DIV_SLOW = 64;
  localparam int FIXED_DIV_FAST = 32;
  // variable-rate modes: overflows per bit, 32 (or 16 doubled)
  localparam int OVF_PER_BIT_SLOW = 32;
  localparam int OVF_PER_BIT_FAST = 16;
  // synchronous mode shift clock is system clock / 12
  localparam int SYNC_DIV = 12;
  localparam int OVERSAMPLE = 16;
  localparam int OVERSAMPLE_MID = 8;
  localparam logic [3:0] FRAME_BITS_8 = 4'h9;
  localparam logic [3:0] FRAME_BITS_9 = 4'hA;

  typedef enum logic [1:0] {
    UMP_MODE_SYNC = 2'b00,
    UMP_MODE_8VAR = 2'b01,
    UMP_MODE_9FIX = 2'b10,
    UMP_MODE_9VAR = 2'b11
  } ump_mode_t;

  typedef enum logic [1:0] {
    UMP_IDLE = 2'b00,
    UMP_START = 2'b01,
    UMP_SHIFT = 2'b11,
    UMP_STOP = 2'b10
  } ump_state_t;

  // a received frame waiting in the buffer
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } ump_frame_t;

endpackage : ump_pkg

// file: rtl/ump_serial_port.sv
// Purpose: control register, split data buffer, framing and address filter of a four-mode serial port
// Assumes: register port is the cpu special-function-register strobe interface; timer overflow arrives as a pulse
// Notes: synchronous mode shifts receive data on the shared data line; the shift clock goes out on tx_line only while transmitting
// Operation
// [R1] master sends address with ninth one first
// [R2] filtered 9-bit receive flags only ninth-one bytes
// [R3] unfiltered 9-bit receive ignores ninth bit
// [R4] 8-bit filter needs stop one; sync ignores
// [R5] filtered slave drops data bytes, no interrupt
// [R6] slave software clears filter on address match
// [R7] bits 7:6 select one of four modes
// [R8] bit 4 enables or disables the receiver
// [R9] bit 3 sent as ninth bit, 9-bit modes
// [R10] bit 2 holds received ninth or stop
// [R11] bit 1 set on transmit done, software clears
// [R12] bit 0 set on receive done, software clears
// [R13] either flag requests the serial interrupt
// [R14] data write loads transmitter and starts sending
// [R15] data read returns the receive register
// [R16] timer reload table assumes doubling, fast clock
// [R17] load receive only while receive flag clear
// [R18] 9-bit frame: start, eight lsb-first, ninth, stop
// [R19] fixed rate is clock over 64 or 32
// [R20] timer overflow clocks baud, over 32 or 16
// [R21] receiver oversamples sixteen times, samples mid-bit
`timescale 1ns/1ps
module ump_serial_port (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // synchronous reset, low active
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, valid cycle after read
  input wire logic baud_double, // doubling select
  input wire logic timer_overflow, // one pulse per baud timer overflow
  input wire logic irq_enable, // serial interrupt enable
  output logic irq_req, // serial interrupt request level
  input wire logic rx_line_in, // receive line level
  output logic rx_line_out, // data out in synchronous mode
  output logic rx_line_oe, // drive enable in synchronous mode
  output logic tx_line // transmit line or shift clock
);

  // ----------------------------------------
  // control register and decoding
  // ----------------------------------------
  logic [1:0] mode;
  logic multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag;
  logic [7:0] tx_shadow;
  ump_pkg::ump_frame_t rx_hold;

  wire wr_ctl = sfr_wr && (sfr_addr == ump_pkg::ADDR_CONTROL);
  wire wr_dat = sfr_wr && (sfr_addr == ump_pkg::ADDR_DATA);
  wire rd_dat = sfr_rd && (sfr_addr == ump_pkg::ADDR_DATA);
  wire is_sync = (mode == ump_pkg::UMP_MODE_SYNC); // [R7]
  wire is_nine = mode[1]; // [R7]
  wire [7:0] ctl_value = {mode, multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag,
    rx_done_flag};

  // ----------------------------------------
  // bit-rate ticks: sixteen per bit, one per bit in sync mode
  // ----------------------------------------
  logic [5:0] fix_cnt;
  logic [4:0] ovf_cnt;
  logic [3:0] sync_cnt;
  // fixed mode: 64 clocks per bit means one oversample tick every 4 (or 2 doubled)
  wire [5:0] fix_lim = baud_double ? 6'(ump_pkg::FIXED_DIV_FAST / ump_pkg::OVERSAMPLE - 1)
                                   : 6'(ump_pkg::FIXED_DIV_SLOW / ump_pkg::OVERSAMPLE - 1);
  // variable mode: 32 overflows per bit means one tick every 2 (or 1 doubled)
  wire [4:0] ovf_lim = baud_double ? 5'(ump_pkg::OVF_PER_BIT_FAST / ump_pkg::OVERSAMPLE - 1)
                                   : 5'(ump_pkg::OVF_PER_BIT_SLOW / ump_pkg::OVERSAMPLE - 1);
  wire fix_tick = (fix_cnt == fix_lim); // [R19]
  wire ovf_tick = timer_overflow && (ovf_cnt == ovf_lim); // [R20]
  wire os_tick = (mode == ump_pkg::UMP_MODE_9FIX) ? fix_tick : ovf_tick;
  wire sync_tick = (sync_cnt == 4'(ump_pkg::SYNC_DIV - 1));

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      fix_cnt <= '0;
      ovf_cnt <= '0;
      sync_cnt <= '0;
    end
    else
    begin
      fix_cnt <= fix_tick ? 6'h0 : fix_cnt + 6'h1;
      if (timer_overflow)
        ovf_cnt <= (ovf_cnt == ovf_lim) ? 5'h0 : ovf_cnt + 5'h1;
      sync_cnt <= sync_tick ? 4'h0 : sync_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  ump_pkg::ump_state_t tx_state;
  logic [3:0] tx_os, tx_bits;
  logic [8:0] tx_shift;
  logic tx_go;
  wire tx_bit_end = os_tick && (tx_os == 4'hF);
  wire [3:0] tx_last = is_nine ? ump_pkg::FRAME_BITS_9 : ump_pkg::FRAME_BITS_8;
  // flag rises entering the stop bit, or after the eighth bit in sync mode
  wire tx_set = is_sync ? (tx_state == ump_pkg::UMP_SHIFT && sync_tick && tx_bits == 4'h7)
                        : (tx_state == ump_pkg::UMP_SHIFT && tx_bit_end && tx_bits == tx_last - 4'h2);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tx_state <= ump_pkg::UMP_IDLE;
      tx_os <= '0;
      tx_bits <= '0;
      tx_shift <= '0;
      tx_go <= 1'b0;
      tx_line <= 1'b1;
      rx_line_out <= 1'b1;
      rx_line_oe <= 1'b0;
    end
    else
    begin
      case (tx_state)
        ump_pkg::UMP_IDLE:
        begin
          tx_line <= 1'b1;
          rx_line_oe <= 1'b0;
          if (tx_go && (is_sync ? sync_tick : os_tick))
          begin
            tx_go <= 1'b0;
            // 8-bit modes load a 1 in the ninth slot, so that slot becomes the stop bit
            tx_shift <= {is_nine ? tx_ninth_bit : 1'b1, tx_shadow}; // [R9] [R14]
            tx_os <= '0;
            tx_bits <= '0;
            tx_state <= is_sync ? ump_pkg::UMP_SHIFT : ump_pkg::UMP_START;
            if (!is_sync)
              tx_line <= 1'b0;
          end
        end
        ump_pkg::UMP_START:
          if (tx_bit_end)
          begin
            tx_line <= tx_shift[0]; // [R18]
            tx_shift <= {1'b1, tx_shift[8:1]};
            tx_os <= '0;
            tx_state <= ump_pkg::UMP_SHIFT;
          end
          else if (os_tick)
            tx_os <= tx_os + 4'h1;
        ump_pkg::UMP_SHIFT:
          if (is_sync)
          begin
            rx_line_oe <= 1'b1;
            rx_line_out <= tx_shift[0];
            tx_line <= ~sync_tick;
            if (sync_tick)
            begin
              tx_shift <= {1'b1, tx_shift[8:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == 4'h7)
                tx_state <= ump_pkg::UMP_IDLE;
            end
          end
          else if (tx_bit_end)
          begin
            tx_bits <= tx_bits + 4'h1;
            // ninth bit is shifted only in 9-bit modes; the 1 filled in is the stop bit
            tx_line <= tx_shift[0]; // [R18]
            tx_shift <= {1'b1, tx_shift[8:1]};
            if (tx_bits == tx_last - 4'h2)
              tx_state <= ump_pkg::UMP_STOP;
            tx_os <= '0;
          end
          else if (os_tick)
            tx_os <= tx_os + 4'h1;
        ump_pkg::UMP_STOP:
          if (tx_bit_end)
            tx_state <= ump_pkg::UMP_IDLE;
          else if (os_tick)
            tx_os <= tx_os + 4'h1;
        default:
          tx_state <= ump_pkg::UMP_IDLE;
      endcase
      // after the state machine: a write landing on the launch edge re-arms instead of being lost
      if (wr_dat)
        tx_go <= 1'b1; // [R14]
    end
  end

  // ----------------------------------------
  // receiver: start detect and mid-bit sampling
  // ----------------------------------------
  ump_pkg::ump_state_t rx_state;
  logic [3:0] rx_os, rx_bits;
  logic [8:0] rx_shift;
  logic rx_prev;
  logic frame_vld;
  ump_pkg::ump_frame_t frame_word;
  wire rx_mid = os_tick && (rx_os == 4'(ump_pkg::OVERSAMPLE_MID - 1)); // [R21]
  wire rx_bit_end = os_tick && (rx_os == 4'hF);
  wire start_edge = rx_prev && !rx_line_in; // [R21]
  // mid-sample of the stop bit in every asynchronous mode; in 9-bit modes the ninth bit is already in rx_shift[8]
  wire rx_last_mid = rx_state == ump_pkg::UMP_STOP && rx_mid;
  wire [8:0] rx_done9 = rx_shift;

  // a frame passes the address filter
  wire stop_or_ninth = is_nine ? rx_done9[8] : rx_line_in;
  wire filter_ok = !multiproc_enable || stop_or_ninth; // [R2] [R3] [R4] [R5]

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rx_state <= ump_pkg::UMP_IDLE;
      rx_os <= '0;
      rx_bits <= '0;
      rx_shift <= '0;
      rx_prev <= 1'b1;
      frame_vld <= 1'b0;
      frame_word <= '0;
    end
    else
    begin
      rx_prev <= rx_line_in;
      frame_vld <= 1'b0;
      case (rx_state)
        ump_pkg::UMP_IDLE:
        begin
          rx_os <= '0;
          rx_bits <= '0;
          if (rx_enable && !is_sync && start_edge) // [R8]
            rx_state <= ump_pkg::UMP_START;
          else if (rx_enable && is_sync && !rx_done_flag) // [R8]
            rx_state <= ump_pkg::UMP_SHIFT;
        end
        ump_pkg::UMP_START:
          if (rx_mid && rx_line_in)
            rx_state <= ump_pkg::UMP_IDLE; // false start
          else if (rx_bit_end)
          begin
            rx_os <= '0;
            rx_state <= ump_pkg::UMP_SHIFT;
          end
          else if (os_tick)
            rx_os <= rx_os + 4'h1;
        ump_pkg::UMP_SHIFT:
          if (is_sync)
          begin
            if (sync_tick)
            begin
              rx_shift <= {1'b0, rx_line_in, rx_shift[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == 4'h7)
              begin
                frame_vld <= 1'b1; // [R12]
                frame_word <= '{data: {rx_line_in, rx_shift[7:1]}, ninth: rx_ninth_bit};
                rx_state <= ump_pkg::UMP_IDLE;
              end
            end
          end
          else
          begin
            if (rx_mid)
            begin
              rx_shift <= is_nine ? {rx_line_in, rx_shift[8:1]} : {1'b0, rx_line_in, rx_shift[7:1]}; // [R18]
              rx_bits <= rx_bits + 4'h1;
            end
            if (rx_bit_end && rx_bits == tx_last - 4'h1)
              rx_state <= ump_pkg::UMP_STOP;
            rx_os <= os_tick ? rx_os + 4'h1 : rx_os;
          end
        ump_pkg::UMP_STOP:
          if (rx_last_mid)
          begin
            rx_state <= ump_pkg::UMP_IDLE;
            frame_vld <= filter_ok;
            // mode 1 with filter clear keeps the stop bit; 9-bit keeps ninth
            frame_word <= '{data: is_nine ? rx_done9[7:0] : rx_shift[7:0],
                            ninth: is_nine ? rx_done9[8] : rx_line_in}; // [R10]
          end
          else if (os_tick)
            rx_os <= rx_os + 4'h1;
        default:
          rx_state <= ump_pkg::UMP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // two-entry buffer between receiver and cpu-visible register
  // ----------------------------------------
  ump_pkg::ump_frame_t buf_mem [2];
  logic buf_wp, buf_rp;
  logic [1:0] buf_cnt;
  wire buf_in_ready = (buf_cnt != 2'd2);
  wire buf_out_valid = (buf_cnt != 2'd0);
  // a frame is drained only while the receive flag is clear
  wire buf_out_ready = !rx_done_flag; // [R17]
  wire buf_push = frame_vld && buf_in_ready;
  wire buf_pop = buf_out_valid && buf_out_ready;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= '0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_mem[buf_wp] <= frame_word;
        buf_wp <= ~buf_wp;
      end
      if (buf_pop)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
    end
  end

  // ----------------------------------------
  // register state, flags and interrupt
  // ----------------------------------------
  ump_pkg::ump_frame_t pop_word;
  assign pop_word = buf_mem[buf_rp];
  wire next_rx_ninth_load = buf_pop && !is_sync;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      {mode, multiproc_enable, rx_enable, tx_ninth_bit} <= ump_pkg::CONTROL_RESET[7:3];
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      tx_shadow <= ump_pkg::DATA_RESET;
      rx_hold <= '0;
      sfr_rdata <= '0;
      irq_req <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        {mode, multiproc_enable, rx_enable, tx_ninth_bit} <= sfr_wdata[7:3]; // [R7] [R8] [R9]
        rx_ninth_bit <= sfr_wdata[ump_pkg::BIT_RX_NINTH];
      end
      if (wr_dat)
        tx_shadow <= sfr_wdata; // [R14]
      // hardware set wins over a software clear in the same cycle
      tx_done_flag <= tx_set || (wr_ctl ? sfr_wdata[ump_pkg::BIT_TX_DONE] : tx_done_flag); // [R11]
      rx_done_flag <= buf_pop || (wr_ctl ? sfr_wdata[ump_pkg::BIT_RX_DONE] : rx_done_flag); // [R12] [R17]
      if (buf_pop)
        rx_hold <= pop_word; // [R17]
      if (next_rx_ninth_load)
        rx_ninth_bit <= pop_word.ninth; // [R10]
      if (sfr_rd)
        sfr_rdata <= rd_dat ? rx_hold.data : (sfr_addr == ump_pkg::ADDR_CONTROL) ? ctl_value : 8'h00; // [R15]
      irq_req <= irq_enable && (tx_done_flag || rx_done_flag); // [R13]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence rx_loaded_s;
    buf_pop ##1 rx_done_flag;
  endsequence

  rx_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R17]
    rx_done_flag |=> $stable(rx_hold)) else $error("receive loaded while flag set");
  rx_set_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R12]
    buf_pop |-> rx_loaded_s) else $error("receive flag not set on load");
  tx_set_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R11]
    tx_set |=> tx_done_flag) else $error("transmit flag not set");
  filter_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R5]
    (rx_last_mid && is_nine && multiproc_enable && !rx_done9[8]) |=> !frame_vld)
    else $error("data byte passed filter");
  irq_req_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R13]
    (irq_enable && rx_done_flag) |=> irq_req) else $error("interrupt not requested");
  rx_off_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R8]
    (rx_state == ump_pkg::UMP_IDLE && !rx_enable) |=> rx_state == ump_pkg::UMP_IDLE)
    else $error("receiver ran while off");
  tx_start_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R14]
    wr_dat |=> tx_go) else $error("data write did not arm transmit");
  rd_data_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [R15]
    rd_dat |=> sfr_rdata == $past(rx_hold.data)) else $error("data read not receive register");

endmodule : ump_serial_port

// file: tb/ump_far_port.sv
// Purpose: far-side serial port that frames bytes into the device and captures what it sends
// Assumes: bit time is given in system clocks; the line idles high
// Notes: behavioural; the caller picks the ninth bit, so address-then-data order is the caller's duty
`timescale 1ns/1ps
module ump_far_port (
  input wire logic core_clk, // system clock
  input wire logic from_dut, // device transmit line
  output logic to_dut // line into the device receiver
);
  initial to_dut = 1'b1;

  task automatic send_frame(input logic [7:0] data, input logic ninth, input logic stop, input logic nine,
                            input int bclk);
    logic [10:0] bits;
    // start low, data lsb first, ninth slot only in 9-bit modes, then stop
    bits = nine ? {stop, ninth, data, 1'b0} : {1'b1, stop, data, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      @(posedge core_clk);
      to_dut <= bits[i];
      repeat (bclk - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    to_dut <= 1'b1;
  endtask : send_frame

  task automatic recv_frame(input logic nine, input int bclk, output logic [7:0] data, output logic ninth,
                            output logic ok);
    logic [10:0] bits;
    int t;
    t = 0;
    bits = '1;
    // bounded wait for the start edge; a silent device leaves ok low
    while (from_dut !== 1'b0 && t < 4000)
    begin
      @(posedge core_clk);
      t++;
    end
    repeat (bclk / 2) @(posedge core_clk);
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      bits[i] = from_dut;
      repeat (bclk) @(posedge core_clk);
    end
    data = bits[8:1];
    ninth = bits[9];
    ok = (bits[0] === 1'b0) && (bits[nine ? 10 : 9] === 1'b1);
  endtask : recv_frame
endmodule : ump_far_port

// file: tb/tb.sv
// Purpose: self-checking bench for the multiprocessor serial port
// Assumes: 40 MHz clock; baud timer overflow every other clock
// Notes: rows cover receive filtering; transmit, buffer and sync cases follow by hand
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] data;
    logic ninth;
    logic stop;
    logic dbl;
    logic [7:0] exp_ctl;
  } ump_row_t;

  logic core_clk, reset_n, sfr_wr, sfr_rd, baud_double, timer_overflow, irq_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, last_rx, rd, tx_d;
  logic irq_req, rx_line_out, rx_line_oe, tx_line, far_line, rx_wire, tx_n, tx_ok;
  int err_count, tests_run;
  ump_row_t rows [11];

  // the device drives the receive pin only while its enable is high
  assign rx_wire = rx_line_oe ? rx_line_out : far_line;

  ump_serial_port i_ump_serial_port (
    .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_double(baud_double),
    .timer_overflow(timer_overflow), .irq_enable(irq_enable), .irq_req(irq_req), .rx_line_in(rx_wire),
    .rx_line_out(rx_line_out), .rx_line_oe(rx_line_oe), .tx_line(tx_line)
  );
  ump_far_port far_port (.core_clk(core_clk), .from_dut(tx_line), .to_dut(far_line));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // overflow every other clock stands in for the reload timer
  always @(posedge core_clk) timer_overflow <= ~timer_overflow;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(posedge core_clk);
    #1 rd = sfr_rdata;
  endtask : rdreg

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // far bound on the whole run, about five times the expected length
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{
      '{8'hD0, 8'h3C, 1'b0, 1'b1, 1'b1, 8'hD1},
      '{8'hF0, 8'h5A, 1'b0, 1'b1, 1'b1, 8'hF0},
      '{8'hF0, 8'h81, 1'b1, 1'b1, 1'b1, 8'hF5},
      '{8'hD0, 8'hC3, 1'b1, 1'b1, 1'b0, 8'hD5},
      '{8'hB0, 8'h42, 1'b1, 1'b1, 1'b0, 8'hB5},
      '{8'hB0, 8'h24, 1'b0, 1'b1, 1'b1, 8'hB0},
      '{8'h90, 8'h99, 1'b1, 1'b1, 1'b1, 8'h95},
      '{8'h70, 8'h11, 1'b0, 1'b0, 1'b1, 8'h70},
      '{8'h50, 8'h22, 1'b0, 1'b0, 1'b1, 8'h51},
      '{8'h50, 8'h33, 1'b0, 1'b1, 1'b1, 8'h55},
      '{8'h40, 8'h44, 1'b0, 1'b1, 1'b1, 8'h40}
    };
    reset_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    baud_double = 1'b1;
    timer_overflow = 1'b0;
    irq_enable = 1'b0;
    err_count = 0;
    tests_run = 0;
    last_rx = 8'h00;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rdreg(8'h98);
    chk("control reset", 8'h00, rd);
    rdreg(8'h99);
    chk("data reset", 8'h00, rd);
    chk("tx idle", 8'h01, {7'h00, tx_line});
    chk("irq reset", 8'h00, {7'h00, irq_req});
    wr(8'h97, 8'hFF);
    rdreg(8'h97);
    chk("unmapped read", 8'h00, rd);
    rdreg(8'h98);
    chk("control after unmapped write", 8'h00, rd);

    // receive filtering, one frame per row; flags cleared by each control write
    foreach (rows[i])
    begin
      @(posedge core_clk);
      baud_double <= rows[i].dbl;
      wr(8'h98, rows[i].ctl);
      far_port.send_frame(rows[i].data, rows[i].ninth, rows[i].stop, rows[i].ctl[7], rows[i].dbl ? 32 : 64);
      repeat (rows[i].dbl ? 64 : 128) @(posedge core_clk);
      if (rows[i].exp_ctl[0])
        last_rx = rows[i].data;
      rdreg(8'h98);
      chk("control", rows[i].exp_ctl, rd);
      rdreg(8'h99);
      chk("rx data", last_rx, rd);
    end

    // transmit with ninth bit set, then interrupt gating and software clear
    wr(8'h98, 8'hD8);
    fork
      wr(8'h99, 8'hA5);
      far_port.recv_frame(1'b1, 32, tx_d, tx_n, tx_ok);
    join
    chk("tx data", 8'hA5, tx_d);
    chk("tx ninth", 8'h01, {7'h00, tx_n});
    chk("tx framing", 8'h01, {7'h00, tx_ok});
    rdreg(8'h98);
    chk("control tx done", 8'hDA, rd);
    chk("irq masked", 8'h00, {7'h00, irq_req});
    @(posedge core_clk);
    irq_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("irq raised", 8'h01, {7'h00, irq_req});
    rdreg(8'h99);
    chk("read is receive side", last_rx, rd);
    wr(8'h98, 8'hD8);
    rdreg(8'h98);
    chk("control cleared", 8'hD8, rd);
    chk("irq cleared", 8'h00, {7'h00, irq_req});

    // 8-bit transmit with the ninth-bit control low: the stop slot must still go out high
    wr(8'h98, 8'h50);
    fork
      wr(8'h99, 8'h3A);
      far_port.recv_frame(1'b0, 32, tx_d, tx_n, tx_ok);
    join
    chk("tx8 data", 8'h3A, tx_d);
    chk("tx8 framing", 8'h01, {7'h00, tx_ok});
    rdreg(8'h98);
    chk("control tx8 done", 8'h52, rd);

    // four frames while the flag is held: two wait in the buffer, the last is lost
    wr(8'h98, 8'hD0);
    for (int k = 0; k < 4; k++)
    begin
      far_port.send_frame(8'h61 + k[7:0], 1'b0, 1'b1, 1'b1, 32);
      repeat (32) @(posedge core_clk);
    end
    for (int k = 0; k < 3; k++)
    begin
      rdreg(8'h99);
      chk("buffered data", 8'h61 + k[7:0], rd);
      rdreg(8'h98);
      chk("control held", 8'hD1, rd);
      wr(8'h98, 8'hD0);
      repeat (4) @(posedge core_clk);
    end
    rdreg(8'h98);
    chk("drained control", 8'hD0, rd);

    // synchronous transmit: data leaves on the receive pin, one low shift-clock pulse per bit
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h96);
    for (int b = 0; b < 8; b++)
    begin
      @(negedge tx_line);
      #1 tx_d[b] = rx_line_out;
    end
    chk("sync drive enable", 8'h01, {7'h00, rx_line_oe});
    chk("sync tx data", 8'h96, tx_d);
    rdreg(8'h98);
    chk("sync tx done", 8'h02, rd);
    chk("sync drive released", 8'h00, {7'h00, rx_line_oe});

    // synchronous receive ignores the multiprocessor enable; idle line shifts in ones
    wr(8'h98, 8'h30);
    repeat (300) @(posedge core_clk);
    rdreg(8'h98);
    chk("sync rx flag", 8'h01, {7'h00, rd[0]});
    rdreg(8'h99);
    chk("sync rx data", 8'hFF, rd);

    // reset in mid-run, with the receive flag set and its byte held, clears everything
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rdreg(8'h98);
    chk("control after reset", 8'h00, rd);
    rdreg(8'h99);
    chk("data after reset", 8'h00, rd);
    chk("irq after reset", 8'h00, {7'h00, irq_req});
    chk("tx after reset", 8'h01, {7'h00, tx_line});
    print_verdict();
  end
endmodule : tb
